//--- rcx_pkg.sv
// Purpose: Shared constants and types for the register copy execution unit
// Assumes: 32 global/local registers of 32 bits, four 80-bit floating-point registers
// Notes:   Extended real is sign, 15-bit exponent, 64-bit mantissa with explicit integer bit
package rcx_pkg;

    // Instruction opcodes, 12-bit register format
    localparam logic [11:0] RCX_OP_MOV   = 12'h5CC;
    localparam logic [11:0] RCX_OP_MOVL  = 12'h5DC;
    localparam logic [11:0] RCX_OP_MOVT  = 12'h5EC;
    localparam logic [11:0] RCX_OP_MOVQ  = 12'h5FC;
    localparam logic [11:0] RCX_OP_MOVR  = 12'h6C9;
    localparam logic [11:0] RCX_OP_MOVRL = 12'h6D9;
    localparam logic [11:0] RCX_OP_MOVRE = 12'h6E9;

    // Words moved per copy kind
    localparam logic [2:0] RCX_CNT_ONE   = 3'h1;
    localparam logic [2:0] RCX_CNT_TWO   = 3'h2;
    localparam logic [2:0] RCX_CNT_THREE = 3'h3;
    localparam logic [2:0] RCX_CNT_FOUR  = 3'h4;
    localparam logic [2:0] RCX_CNT_NONE  = 3'h0;

    // Register file sizes
    localparam int RCX_GL_REGS = 32;
    localparam int RCX_FP_REGS = 4;

    // Exponent biases and limits, 17-bit signed arithmetic except the 15-bit unsigned extended maximum
    localparam logic signed [16:0] RCX_EXT_BIAS = 17'sh03FFF;
    localparam logic signed [16:0] RCX_SGL_BIAS = 17'sh0007F;
    localparam logic signed [16:0] RCX_DBL_BIAS = 17'sh003FF;
    localparam logic signed [16:0] RCX_SGL_EMAX = 17'sh000FF;
    localparam logic signed [16:0] RCX_DBL_EMAX = 17'sh007FF;
    localparam logic [14:0]        RCX_EXT_EMAX = 15'h7FFF;

    // Fraction widths of the narrow formats
    localparam logic signed [16:0] RCX_SGL_FRAC = 17'sh00017;
    localparam logic signed [16:0] RCX_DBL_FRAC = 17'sh00034;

    // Floating literals: +0.0 and +1.0 in extended form
    localparam logic [79:0] RCX_LIT_ZERO = 80'h0;
    localparam logic [79:0] RCX_LIT_ONE  = 80'h3FFF_8000_0000_0000_0000;

    // Zero value that fills the discarded top field of the third extended word
    localparam logic [15:0] RCX_PAD16 = 16'h0000;

    // Floating exception flags
    typedef struct packed {
        logic inv;
        logic ovf;
        logic unf;
        logic inx;
    } rcx_exc_t;

    // One decoded register-format instruction
    typedef struct packed {
        logic [11:0] opcode;
        logic [4:0]  src;
        logic [4:0]  dst;
        logic        src_lit;
        logic        src_fp;
        logic        dst_fp;
    } rcx_instr_t;

    // Arithmetic controls that matter here; a mask bit of 1 masks the fault
    typedef struct packed {
        logic     norm_mode;
        rcx_exc_t exc_mask;
    } rcx_ctrl_t;

endpackage : rcx_pkg

//--- rcx_fpconv.sv
// Purpose: Combinational real format conversion to and from extended real
// Assumes: Round to nearest even; narrow input is real (low word) or long real
// Notes:   Both directions are evaluated at once; the caller picks the results
`timescale 1ns/1ps
`default_nettype none
module rcx_fpconv
    import rcx_pkg::*;
(
    input  wire logic        is_long_in,
    input  wire logic        norm_mode_in,
    input  wire logic [63:0] narrow_in,
    input  wire logic [79:0] ext_in,
    output logic      [79:0] ext_out,
    output logic      [63:0] narrow_out,
    output rcx_exc_t         w_exc_out,
    output rcx_exc_t         n_exc_out,
    output logic             w_rsv_out,
    output logic             n_rsv_out
);

    // Leading zero count of a 64-bit mantissa
    function automatic logic [6:0] rcx_lzc(input logic [63:0] v);
        logic [6:0] n;
        n = 7'h40;
        for (int i = 0; i < 64; i++) begin
            if (v[i]) n = 7'(63 - i);
        end
        return n;
    endfunction : rcx_lzc

    // Widening: unpack the narrow source
    wire logic        w_sign = is_long_in ? narrow_in[63] : narrow_in[31];
    wire logic [10:0] w_exp  = is_long_in ? narrow_in[62:52] : {3'h0, narrow_in[30:23]};
    wire logic [62:0] w_frac = is_long_in ? {narrow_in[51:0], 11'h0} : {narrow_in[22:0], 40'h0};
    wire logic [10:0] w_emax = is_long_in ? RCX_DBL_EMAX[10:0] : RCX_SGL_EMAX[10:0];
    wire logic signed [16:0] w_bias = is_long_in ? RCX_DBL_BIAS : RCX_SGL_BIAS;
    wire logic        w_den  = (w_exp == 11'h0) && (w_frac != 63'h0);
    wire logic        w_zero = (w_exp == 11'h0) && (w_frac == 63'h0);
    wire logic        w_spec = (w_exp == w_emax);
    wire logic [63:0] w_m    = {(w_exp != 11'h0), w_frac};
    wire logic [6:0]  w_lz   = rcx_lzc(w_m);
    wire logic [63:0] w_mn   = w_m << w_lz;
    wire logic signed [16:0] w_e = $signed({6'h0, (w_den ? 11'h1 : w_exp)})
                                   + RCX_EXT_BIAS - w_bias - $signed({10'h0, w_lz});

    // Widening result, quieting a signalling NaN
    assign ext_out = w_zero ? {w_sign, 79'h0} :
                     (w_spec && w_frac == 63'h0) ? {w_sign, RCX_EXT_EMAX, 64'h8000_0000_0000_0000} :
                     w_spec ? {w_sign, RCX_EXT_EMAX, 2'h3, w_frac[61:0]} :
                     {w_sign, w_e[14:0], w_mn};
    assign w_exc_out = '{inv: w_spec && (w_frac != 63'h0) && !w_frac[62],
                         ovf: 1'b0, unf: 1'b0, inx: 1'b0};
    assign w_rsv_out = w_den && norm_mode_in;

    // Narrowing: unpack the extended source
    wire logic        n_sign = ext_in[79];
    wire logic [14:0] n_exp  = ext_in[78:64];
    wire logic [63:0] n_m    = ext_in[63:0];
    wire logic        n_spec = (n_exp == RCX_EXT_EMAX);
    wire logic        n_zero = !n_spec && (n_m == 64'h0);
    wire logic        n_unn  = !n_spec && !n_zero && !n_m[63];
    wire logic [6:0]  n_lz   = rcx_lzc(n_m);
    wire logic [63:0] n_mn   = n_m << n_lz;
    wire logic signed [16:0] n_bias = is_long_in ? RCX_DBL_BIAS : RCX_SGL_BIAS;
    wire logic signed [16:0] n_emax = is_long_in ? RCX_DBL_EMAX : RCX_SGL_EMAX;
    wire logic signed [16:0] n_fw   = is_long_in ? RCX_DBL_FRAC : RCX_SGL_FRAC;
    wire logic signed [16:0] n_et   = $signed({2'h0, (n_exp == 15'h0 ? 15'h1 : n_exp)})
                                      - RCX_EXT_BIAS + n_bias - $signed({10'h0, n_lz});
    wire logic        n_sub  = (n_et <= 17'sh0);

    // Shift to the target precision, extra for subnormal results
    wire logic signed [16:0] n_sraw = 17'sh0003F - n_fw + (n_sub ? (17'sh1 - n_et) : 17'sh0);
    wire logic [6:0]   n_s    = (n_sraw > 17'sh0007F) ? 7'h7F : n_sraw[6:0];
    wire logic [127:0] n_wide = {n_mn, 64'h0} >> n_s;
    wire logic [63:0]  n_kept = n_wide[127:64];
    wire logic         n_g    = n_wide[63];
    wire logic         n_st   = |n_wide[62:0];
    wire logic         n_inx  = n_g || n_st;
    wire logic         n_inc  = n_g && (n_st || n_kept[0]);
    wire logic [10:0]  n_ef   = n_sub ? 11'h0 : n_et[10:0];

    // Round by adding into the packed magnitude so carries reach the exponent
    wire logic [62:0] n_mag   = is_long_in ? {n_ef, n_kept[51:0]} :
                                             {32'h0, n_ef[7:0], n_kept[22:0]};
    wire logic [62:0] n_mag_r = n_mag + {62'h0, n_inc};
    wire logic        n_rovf  = is_long_in ? (n_mag_r[62:52] == 11'h7FF) :
                                             (n_mag_r[30:23] == 8'hFF);
    wire logic        n_ovf   = !n_spec && !n_zero && ((n_et >= n_emax) || n_rovf);
    wire logic        n_snan  = n_spec && (n_m[62:0] != 63'h0) && !n_m[62];
    wire logic [63:0] n_inf   = is_long_in ? {n_sign, 11'h7FF, 52'h0} :
                                             {32'h0, n_sign, 8'hFF, 23'h0};
    wire logic [63:0] n_nan   = is_long_in ? {n_sign, 11'h7FF, 1'b1, n_m[61:11]} :
                                             {32'h0, n_sign, 8'hFF, 1'b1, n_m[61:40]};
    wire logic [63:0] n_zres  = is_long_in ? {n_sign, 63'h0} : {32'h0, n_sign, 31'h0};
    wire logic [63:0] n_norm  = is_long_in ? {n_sign, n_mag_r} :
                                             {32'h0, n_sign, n_mag_r[30:0]};

    // Narrowing result and its exceptions
    assign narrow_out = n_spec ? ((n_m[62:0] == 63'h0) ? n_inf : n_nan) :
                        n_zero ? n_zres :
                        n_ovf  ? n_inf : n_norm;
    assign n_exc_out = '{inv: n_snan,
                         ovf: n_ovf,
                         unf: !n_spec && !n_zero && n_sub && n_inx,
                         inx: !n_spec && !n_zero && (n_inx || n_ovf)};
    assign n_rsv_out = n_unn && norm_mode_in;

endmodule : rcx_fpconv
`default_nettype wire

//--- rcx_copy_exec.sv
// Purpose: Execution unit for integer and real register copy instructions
// Assumes: One instruction per cycle, taken on a clock edge while valid is high
// Notes:   Source operands are read before the edge, results written at that edge
`timescale 1ns/1ps
`default_nettype none
module rcx_copy_exec
    import rcx_pkg::*;
#(
    parameter int GL_REGS = RCX_GL_REGS,
    parameter int FP_REGS = RCX_FP_REGS
) (
    input  wire logic        MCLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        INSTR_VALID_IN,
    input  wire rcx_instr_t  INSTR_IN,
    input  wire rcx_ctrl_t   CTRL_IN,
    input  wire logic        WR_EN_IN,
    input  wire logic [4:0]  WR_ADDR_IN,
    input  wire logic [31:0] WR_DATA_IN,
    input  wire logic [4:0]  RD_ADDR_IN,
    input  wire logic [1:0]  FP_RD_ADDR_IN,
    output logic      [31:0] RD_DATA_OUT,
    output logic      [79:0] FP_RD_DATA_OUT,
    output logic             DONE_OUT,
    output rcx_exc_t         EXC_OUT,
    output logic             FAULT_OUT,
    output logic             RSV_FAULT_OUT,
    output logic             OP_FAULT_OUT
);

    // Architectural register files
    logic [31:0] gl [GL_REGS];
    logic [79:0] fp [FP_REGS];

    // Opcode decode
    wire logic is_mov   = (INSTR_IN.opcode == RCX_OP_MOV);
    wire logic is_movl  = (INSTR_IN.opcode == RCX_OP_MOVL);
    wire logic is_movt  = (INSTR_IN.opcode == RCX_OP_MOVT);
    wire logic is_movq  = (INSTR_IN.opcode == RCX_OP_MOVQ);
    wire logic is_movr  = (INSTR_IN.opcode == RCX_OP_MOVR);
    wire logic is_movrl = (INSTR_IN.opcode == RCX_OP_MOVRL);
    wire logic is_movre = (INSTR_IN.opcode == RCX_OP_MOVRE);
    wire logic is_int   = is_mov || is_movl || is_movt || is_movq;
    wire logic is_real  = is_movr || is_movrl || is_movre;

    // Operand routing flags
    wire logic src_gl   = !INSTR_IN.src_lit && !INSTR_IN.src_fp;
    wire logic dst_gl   = !INSTR_IN.dst_fp;
    wire logic bad_lit  = is_real && INSTR_IN.src_lit && (INSTR_IN.src[4:1] != 4'h0);
    wire logic bad_int  = is_int && (INSTR_IN.src_fp || INSTR_IN.dst_fp);
    wire logic op_fault = INSTR_VALID_IN && (!(is_int || is_real) || bad_lit || bad_int);

    // Integer word count
    wire logic [2:0] int_cnt = is_mov  ? RCX_CNT_ONE :
                               is_movl ? RCX_CNT_TWO :
                               is_movt ? RCX_CNT_THREE :
                               is_movq ? RCX_CNT_FOUR : RCX_CNT_NONE;

    // Source words in ascending order; a literal fills the lowest word only
    logic [31:0] src_word [4];
    generate
        for (genvar k = 0; k < 4; k++) begin : g_src
            wire logic [4:0] rd_idx = INSTR_IN.src + 5'(k);
            assign src_word[k] = INSTR_IN.src_lit ?
                                 ((k == 0) ? {27'h0, INSTR_IN.src} : 32'h0) :
                                 gl[rd_idx];
        end
    endgenerate

    // Conversion unit shared by the real copies
    logic [79:0] w_ext;
    logic [79:0] src_ext;
    logic [63:0] n_val;
    rcx_exc_t    w_exc;
    rcx_exc_t    n_exc;
    logic        w_rsv;
    logic        n_rsv;

    rcx_fpconv u_conv (
        .is_long_in   (is_movrl),
        .norm_mode_in (CTRL_IN.norm_mode),
        .narrow_in    ({src_word[1], src_word[0]}),
        .ext_in       (src_ext),
        .ext_out      (w_ext),
        .narrow_out   (n_val),
        .w_exc_out    (w_exc),
        .n_exc_out    (n_exc),
        .w_rsv_out    (w_rsv),
        .n_rsv_out    (n_rsv)
    );

    // Extended value from three global/local words, top half of third word dropped
    wire logic [79:0] gl_ext  = {src_word[2][15:0], src_word[1], src_word[0]};
    wire logic [79:0] lit_ext = INSTR_IN.src[0] ? RCX_LIT_ONE : RCX_LIT_ZERO;
    wire logic [1:0]  fp_sidx = INSTR_IN.src[1:0];

    // Source in extended form; real to long real thus always passes a floating register
    assign src_ext = INSTR_IN.src_lit ? lit_ext :
                     INSTR_IN.src_fp  ? fp[fp_sidx] :
                     is_movre         ? gl_ext : w_ext;

    // Exceptions: widening checks a global/local source, narrowing a global/local target
    wire logic      num_op  = is_movr || is_movrl;
    wire rcx_exc_t  exc_raw = (src_gl ? w_exc : 4'h0) | (dst_gl ? n_exc : 4'h0);
    wire rcx_exc_t  exc     = num_op ? exc_raw : 4'h0;
    wire logic      rsv     = num_op && ((src_gl && w_rsv) || (dst_gl && n_rsv));
    wire logic      arith_f = |(exc & ~CTRL_IN.exc_mask);
    wire logic      fault   = INSTR_VALID_IN && !op_fault && num_op && (rsv || arith_f);
    wire logic      commit  = INSTR_VALID_IN && !op_fault && !fault;

    // Words written into global/local registers
    wire logic [2:0] real_cnt = !dst_gl   ? RCX_CNT_NONE :
                                is_movr   ? RCX_CNT_ONE :
                                is_movrl  ? RCX_CNT_TWO : RCX_CNT_THREE;
    wire logic [2:0] slot_cnt = commit ? (is_int ? int_cnt : real_cnt) : RCX_CNT_NONE;

    // Per-slot write data
    logic [31:0] slot_data [4];
    assign slot_data[0] = is_int ? src_word[0] : is_movre ? src_ext[31:0]  : n_val[31:0];
    assign slot_data[1] = is_int ? src_word[1] : is_movre ? src_ext[63:32] : n_val[63:32];
    assign slot_data[2] = is_int ? src_word[2] : {RCX_PAD16, src_ext[79:64]};
    assign slot_data[3] = src_word[3];

    // Per-entry write decode; with overlap the highest slot wins, result left undefined
    logic        ent_we [GL_REGS];
    logic [31:0] ent_wd [GL_REGS];
    generate
        for (genvar i = 0; i < GL_REGS; i++) begin : g_ent
            always_comb begin
                ent_we[i] = 1'b0;
                ent_wd[i] = 32'h0;
                for (int k = 0; k < 4; k++) begin
                    if ((3'(k) < slot_cnt) && (5'(INSTR_IN.dst + 5'(k)) == 5'(i))) begin
                        ent_we[i] = 1'b1;
                        ent_wd[i] = slot_data[k];
                    end
                end
            end
        end
    endgenerate

    // Setup port writes only where the instruction does not
    logic [GL_REGS-1:0] set_we;
    generate
        for (genvar i = 0; i < GL_REGS; i++) begin : g_set
            assign set_we[i] = WR_EN_IN && (WR_ADDR_IN == 5'(i));
        end
    endgenerate

    // Global/local register file
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            for (int i = 0; i < GL_REGS; i++) gl[i] <= 32'h0;
        end else begin
            for (int i = 0; i < GL_REGS; i++) begin
                if (ent_we[i]) gl[i] <= ent_wd[i];
                else if (set_we[i]) gl[i] <= WR_DATA_IN;
            end
        end
    end

    // Floating register write: extended value stored as is
    wire logic       fp_we   = commit && is_real && INSTR_IN.dst_fp;
    wire logic [1:0] fp_didx = INSTR_IN.dst[1:0];

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            for (int i = 0; i < FP_REGS; i++) fp[i] <= 80'h0;
        end else if (fp_we) begin
            fp[fp_didx] <= src_ext;
        end
    end

    // Completion and fault reporting, one-cycle pulses
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            DONE_OUT      <= 1'b0;
            EXC_OUT       <= 4'h0;
            FAULT_OUT     <= 1'b0;
            RSV_FAULT_OUT <= 1'b0;
            OP_FAULT_OUT  <= 1'b0;
        end else begin
            DONE_OUT      <= INSTR_VALID_IN;
            EXC_OUT       <= (INSTR_VALID_IN && !op_fault) ? exc : 4'h0;
            FAULT_OUT     <= fault;
            RSV_FAULT_OUT <= fault && rsv;
            OP_FAULT_OUT  <= op_fault;
        end
    end

    // Inspection read ports, registered
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            RD_DATA_OUT    <= 32'h0;
            FP_RD_DATA_OUT <= 80'h0;
        end else begin
            RD_DATA_OUT    <= gl[RD_ADDR_IN];
            FP_RD_DATA_OUT <= fp[FP_RD_ADDR_IN];
        end
    end

endmodule : rcx_copy_exec
`default_nettype wire

//--- rcx_copy_exec_assertions.sv
// Purpose: Port-level assertions for the register copy execution unit
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into rcx_copy_exec at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rcx_copy_exec_chk
    import rcx_pkg::*;
(
    input wire logic       MCLK_IN,
    input wire logic       RESETN_IN,
    input wire logic       INSTR_VALID_IN,
    input wire rcx_instr_t INSTR_IN,
    input wire rcx_ctrl_t  CTRL_IN,
    input wire logic       DONE_OUT,
    input wire rcx_exc_t   EXC_OUT,
    input wire logic       FAULT_OUT,
    input wire logic       RSV_FAULT_OUT,
    input wire logic       OP_FAULT_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);

    // Opcode classes of the instruction on the port
    wire logic [11:0] op      = INSTR_IN.opcode;
    wire logic        is_int  = op inside {RCX_OP_MOV, RCX_OP_MOVL, RCX_OP_MOVT, RCX_OP_MOVQ};
    wire logic        is_num  = op inside {RCX_OP_MOVR, RCX_OP_MOVRL};
    wire logic        is_real = is_num || (op == RCX_OP_MOVRE);
    wire logic        exc_ok  = INSTR_VALID_IN && is_num;
    wire logic        rsv_ok  = exc_ok && CTRL_IN.norm_mode;

    sequence s_take(c);
        INSTR_VALID_IN && c;
    endsequence

    property p_done; INSTR_VALID_IN |=> DONE_OUT; endproperty
    property p_idle; !INSTR_VALID_IN |=> !DONE_OUT && !FAULT_OUT && !OP_FAULT_OUT; endproperty
    property p_int_clean;
        s_take(is_int && !INSTR_IN.src_fp && !INSTR_IN.dst_fp)
            |=> !OP_FAULT_OUT && !FAULT_OUT && EXC_OUT == 4'h0;
    endproperty
    property p_bad_op; s_take(!(is_int || is_real)) |=> OP_FAULT_OUT; endproperty
    property p_real_ok; s_take(is_real && !INSTR_IN.src_lit) |=> !OP_FAULT_OUT; endproperty
    property p_movre; s_take(op == RCX_OP_MOVRE) |=> !FAULT_OUT && EXC_OUT == 4'h0; endproperty
    property p_mask;
        DONE_OUT && !RSV_FAULT_OUT |-> FAULT_OUT == |(4'(EXC_OUT) & ~4'($past(CTRL_IN.exc_mask)));
    endproperty
    property p_rsv; RSV_FAULT_OUT |-> FAULT_OUT && $past(rsv_ok); endproperty
    property p_exc_src; EXC_OUT != 4'h0 |-> DONE_OUT && $past(exc_ok); endproperty

    a_done: assert property (p_done) else $error("no completion after take");
    a_idle: assert property (p_idle) else $error("flags without instruction");
    a_int_clean: assert property (p_int_clean) else $error("integer copy flagged");
    a_bad_op: assert property (p_bad_op) else $error("unknown opcode accepted");
    a_real_ok: assert property (p_real_ok) else $error("real copy refused");
    a_movre: assert property (p_movre) else $error("extended copy flagged");
    a_mask: assert property (p_mask) else $error("fault disagrees with mask");
    a_rsv: assert property (p_rsv) else $error("reserved fault without cause");
    a_exc_src: assert property (p_exc_src) else $error("exception from wrong op");
endmodule : rcx_copy_exec_chk

bind rcx_copy_exec rcx_copy_exec_chk u_rcx_copy_exec_chk (
    .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
    .INSTR_IN(INSTR_IN), .CTRL_IN(CTRL_IN), .DONE_OUT(DONE_OUT), .EXC_OUT(EXC_OUT),
    .FAULT_OUT(FAULT_OUT), .RSV_FAULT_OUT(RSV_FAULT_OUT), .OP_FAULT_OUT(OP_FAULT_OUT)
);
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the register copy execution unit
// Assumes: Inputs change 5 ns after each rising edge
// Notes:   Random integer copies plus fixed real-format corner cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb
    import rcx_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, wr_en = 1'b0;
    rcx_instr_t  instr = '0;
    rcx_ctrl_t   ctrl = '0;
    logic [4:0]  wr_addr = '0, rd_addr = '0, sb, db;
    logic [1:0]  fp_addr = '0;
    logic [31:0] wr_data = '0, rd_data, w [4];
    logic [79:0] fp_data;
    logic        done, fault, rsv, opf, lit;
    logic [2:0]  g;
    rcx_exc_t    exc;
    int          n_errors = 0, tests_run = 0;
    localparam logic [11:0] ops [4] = '{RCX_OP_MOV, RCX_OP_MOVL, RCX_OP_MOVT, RCX_OP_MOVQ};
    localparam logic [79:0] xc [4] = '{80'h3FFF_8000_0000_0000_0001,
        80'h7FFE_8000_0000_0000_0000, 80'h0001_8000_0000_0000_0000, 80'h7FFF_8000_0000_0000_0001};
    localparam logic [3:0]  xe [4] = '{4'h1, 4'h5, 4'h3, 4'h8};

    always #50 clk = ~clk;

    rcx_copy_exec u_rcx_copy_exec (
        .MCLK_IN(clk), .RESETN_IN(rst_n), .INSTR_VALID_IN(vld), .INSTR_IN(instr),
        .CTRL_IN(ctrl), .WR_EN_IN(wr_en), .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data),
        .RD_ADDR_IN(rd_addr), .FP_RD_ADDR_IN(fp_addr), .RD_DATA_OUT(rd_data),
        .FP_RD_DATA_OUT(fp_data), .DONE_OUT(done), .EXC_OUT(exc), .FAULT_OUT(fault),
        .RSV_FAULT_OUT(rsv), .OP_FAULT_OUT(opf)
    );

    // Expected word j of a destination group after an integer copy of kind k
    function automatic logic [31:0] exp_int(int k, int j, logic l, logic [4:0] s,
                                            logic [31:0] d);
        if (j > k) return ~d;
        if (l) return (j == 0) ? {27'h0, s} : 32'h0;
        return d;
    endfunction : exp_int

    // One edge, then let its updates settle
    task automatic step();
        @(posedge clk);
        #5;
    endtask : step

    // Setup write; the strobe stays up until another task lowers it
    task automatic setw(input logic [4:0] a, input logic [31:0] d);
        vld     = 1'b0;
        wr_en   = 1'b1;
        wr_addr = a;
        wr_data = d;
        step();
    endtask : setw

    // Issue one instruction; f is {literal, source fp, destination fp}
    task automatic exec(input logic [11:0] op, input logic [4:0] s, d,
                        input logic [2:0] f, input logic [4:0] c);
        wr_en = 1'b0;
        instr = '{op, s, d, f[2], f[1], f[0]};
        ctrl  = c;
        vld   = 1'b1;
        step();
        `CHK(done, 1'b1)
    endtask : exec

    // Read both register files; results land in rd_data and fp_data
    task automatic rd(input logic [4:0] a);
        vld     = 1'b0;
        wr_en   = 1'b0;
        rd_addr = a;
        fp_addr = a[1:0];
        step();
    endtask : rd

    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        void'($urandom(74));
        repeat (20) @(posedge clk);
        #5 rst_n = 1'b1;
        // Aligned, disjoint integer copies of every width, some from literals
        for (int i = 0; i < 16; i++) begin
            g   = 3'($urandom());
            sb  = {g, 2'h0};
            db  = {3'(g + 3'($urandom_range(1, 7))), 2'h0};
            lit = 1'($urandom());
            for (int j = 0; j < 4; j++) begin
                w[j] = $urandom();
                setw(sb + 5'(j), w[j]);
                setw(db + 5'(j), ~w[j]);
            end
            exec(ops[i % 4], sb, db, {lit, 2'h0}, 5'h00);
            `CHK({opf, fault, 4'(exc)}, 6'h00)
            for (int j = 0; j < 4; j++) begin
                rd(db + 5'(j));
                `CHK(rd_data, exp_int(i % 4, j, lit, sb, w[j]))
            end
        end
        // Refusals leave the destination alone; overlap only has to complete
        setw(5'h1C, 32'h1234_5678);
        exec(12'h5AC, 5'h00, 5'h1C, 3'h0, 5'h00);
        `CHK(opf, 1'b1)
        exec(RCX_OP_MOV, 5'h00, 5'h1C, 3'h1, 5'h00);
        `CHK(opf, 1'b1)
        rd(5'h1C);
        `CHK(rd_data, 32'h1234_5678)
        exec(RCX_OP_MOVQ, 5'h00, 5'h00, 3'h0, 5'h00);
        // Extended bit moves both ways with every fault unmasked
        for (int j = 0; j < 3; j++) begin
            w[j] = $urandom();
            setw(5'h10 + 5'(j), w[j]);
        end
        exec(RCX_OP_MOVRE, 5'h10, 5'h01, 3'h1, 5'h00);
        `CHK({fault, 4'(exc)}, 5'h00)
        rd(5'h01);
        `CHK(fp_data, {w[2][15:0], w[1], w[0]})
        exec(RCX_OP_MOVRE, 5'h01, 5'h14, 3'h2, 5'h00);
        for (int j = 0; j < 3; j++) begin
            rd(5'h14 + 5'(j));
            `CHK(rd_data, (j == 2) ? {16'h0, w[2][15:0]} : w[j])
        end
        // Real 1.0 widened into a floating register, then narrowed to long real
        setw(5'h03, 32'h3F80_0000);
        exec(RCX_OP_MOVR, 5'h03, 5'h02, 3'h1, 5'h1F);
        rd(5'h02);
        `CHK(fp_data, 80'h3FFF_8000_0000_0000_0000)
        exec(RCX_OP_MOVRL, 5'h02, 5'h18, 3'h2, 5'h1F);
        rd(5'h18);
        `CHK(rd_data, 32'h0)
        rd(5'h19);
        `CHK(rd_data, 32'h3FF0_0000)
        // Narrowing to real: unmasked flags fault and block the write
        for (int i = 0; i < 4; i++) begin
            setw(5'h1A, 32'hDEAD_BEEF);
            for (int j = 0; j < 3; j++) setw(5'h10 + 5'(j), 32'(xc[i] >> (32 * j)));
            exec(RCX_OP_MOVRE, 5'h10, 5'h03, 3'h1, 5'h0F);
            exec(RCX_OP_MOVR, 5'h03, 5'h1A, 3'h2, 5'h00);
            `CHK({fault, 4'(exc)}, {1'b1, xe[i]})
            rd(5'h1A);
            `CHK(rd_data, 32'hDEAD_BEEF)
            exec(RCX_OP_MOVR, 5'h03, 5'h1A, 3'h2, 5'h0F);
            `CHK({fault, 4'(exc)}, {1'b0, xe[i]})
        end
        // Real literals: 1 gives +1.0, anything above 1 is refused
        exec(RCX_OP_MOVR, 5'h01, 5'h00, 3'h5, 5'h1F);
        rd(5'h00);
        `CHK(fp_data, 80'h3FFF_8000_0000_0000_0000)
        exec(RCX_OP_MOVR, 5'h02, 5'h00, 3'h5, 5'h1F);
        `CHK(opf, 1'b1)
        // Denormal real source with and without normalizing mode
        setw(5'h05, 32'h0000_0001);
        exec(RCX_OP_MOVR, 5'h05, 5'h00, 3'h1, 5'h1F);
        `CHK({rsv, fault}, 2'h3)
        exec(RCX_OP_MOVR, 5'h05, 5'h00, 3'h1, 5'h0F);
        `CHK({rsv, fault, 4'(exc)}, 6'h00)
        report_and_stop();
    end

    // Cut a hung run short
    initial begin
        #2ms;
        n_errors++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
